// ===== design/sensor_i2c_pkg.sv
// Package: constants and types for the local sensor I2C master
package sensor_i2c_pkg;
    localparam int unsigned CORE_CLK_HZ     = 20000000;
    localparam int unsigned SCL_RATE_HZ     = 100000;
    // Quarter of an SCL period in core cycles
    localparam int unsigned QUARTER_CYCLES  = CORE_CLK_HZ / (SCL_RATE_HZ * 4);
    localparam int unsigned BUS_FREE_CYCLES = QUARTER_CYCLES * 4;
    localparam logic        DIR_WRITE       = 1'h0;
    localparam logic        DIR_READ        = 1'h1;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

    typedef enum logic [1:0] {
        OP_BYTE_WRITE = 2'h0,
        OP_PAGE_WRITE = 2'h1,
        OP_RANDOM_READ = 2'h2,
        OP_SEQ_READ   = 2'h3
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [6:0] target;
        logic [7:0] pointer;
    } cmd_t;
endpackage : sensor_i2c_pkg

// ===== design/local_sensor_i2c_master.sv
// Local sensor I2C master: 100 kHz, 7-bit address, write and read formats
//
// Behaviour
// RQ1: SCL is generated by this master at a fixed 100 kHz.
// RQ2: The target is addressed by seven address bits plus a direction bit, giving separate write and read bytes.
// RQ3: Writes are either a single data byte or a page of several bytes.
// RQ4: Reads are either a random read of one byte or a sequential read of several.
// RQ5: A START is only issued when the bus has been seen free.
// RQ6: A write sends the write address byte, then the 8-bit pointer, then the data.
// RQ7: Any number of data bytes may follow the pointer and the target stores them at successive locations.
// RQ8: The target advances its pointer during the acknowledge of each data byte.
// RQ9: Reading starts with the read address after a repeated START or a fresh START on an idle bus.
// RQ10: After acknowledging the read address the target sends its first byte at once.
// RQ11: In a combined read the repeated START follows on the first SCL pulse after the pointer acknowledge.
// RQ12: The target returns data from the pointer last written.
// RQ13: A random read not-acknowledges its one data byte and then issues STOP.
// RQ14: A sequential read acknowledges every data byte except the last.
// RQ15: A sequential read ends with a not-acknowledge on the last byte followed by STOP.
// RQ16: Sequential reads are unbounded in length and the user must mind target pointer wrap.
// RQ17: Bytes go MSB first with an acknowledge bit on the ninth clock.
`timescale 1ns/1ns
module local_sensor_i2c_master (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 cmd_valid_i,
    input  wire sensor_i2c_pkg::cmd_t cmd_i,
    output logic                      cmd_ready_o,
    input  wire logic                 wr_valid_i,
    input  wire logic [7:0]           wr_data_i,
    input  wire logic                 wr_last_i,
    output logic                      wr_ready_o,
    input  wire logic                 rd_last_i,
    output logic                      rd_valid_o,
    output logic [7:0]                rd_data_o,
    output logic                      done_o,
    output logic                      nack_o,
    input  wire logic                 scl_i,
    output logic                      scl_o,
    output logic                      scl_oe_o,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_START   = 9'h002,
        ST_BYTE    = 9'h004,
        ST_ACK     = 9'h008,
        ST_RESTART = 9'h010,
        ST_STOP    = 9'h020,
        ST_FETCH   = 9'h040,
        ST_DONE    = 9'h080,
        ST_WAIT    = 9'h100
    } state_t;
    typedef enum logic [2:0] {
        PH_ADDR_W = 3'h0,
        PH_POINTER = 3'h1,
        PH_DATA_W = 3'h2,
        PH_ADDR_R = 3'h3,
        PH_DATA_R = 3'h4
    } phase_t;

    state_t               state;
    phase_t               phase;
    sensor_i2c_pkg::cmd_t cmd;
    logic [7:0]           shreg;
    logic [3:0]           bit_cnt;
    logic [1:0]           quarter;
    logic [7:0]           tick_cnt;
    logic                 last_byte;
    logic                 scl_m;
    logic                 scl_s;
    logic                 sda_m;
    logic                 sda_s;
    logic                 sda_prev;
    logic                 scl_prev;
    logic                 bus_busy;
    logic [7:0]           free_cnt;
    logic                 bus_free;
    logic                 tick;

    function automatic logic is_read(input sensor_i2c_pkg::op_t op);
        is_read = (op == sensor_i2c_pkg::OP_RANDOM_READ) || (op == sensor_i2c_pkg::OP_SEQ_READ);
    endfunction : is_read

    // ------------------------------------------------------------
    // Pin synchronisers and bus monitor
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_m <= 1'h1;
            scl_s <= 1'h1;
            sda_m <= 1'h1;
            sda_s <= 1'h1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_prev <= 1'h1;
            scl_prev <= 1'h1;
            bus_busy <= 1'h0;
            free_cnt <= 8'h00;
        end else begin
            sda_prev <= sda_s;
            scl_prev <= scl_s;
            if (scl_s && scl_prev && sda_prev && !sda_s) begin
                bus_busy <= 1'h1;
            end else if (scl_s && scl_prev && !sda_prev && sda_s) begin
                bus_busy <= 1'h0;
            end
            // Bus counts as free only after a full SCL period high on both lines
            if (!scl_s || !sda_s || bus_busy) begin
                free_cnt <= 8'h00;
            end else if (free_cnt != 8'(sensor_i2c_pkg::BUS_FREE_CYCLES)) begin
                free_cnt <= free_cnt + 8'h01;
            end
        end
    end
    assign bus_free = (free_cnt == 8'(sensor_i2c_pkg::BUS_FREE_CYCLES)); // [RQ5]

    // ------------------------------------------------------------
    // Quarter-period timebase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt <= 8'h00;
        end else if (state == ST_IDLE || tick) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end
    assign tick = (tick_cnt == 8'(sensor_i2c_pkg::QUARTER_CYCLES - 1)); // [RQ1]

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    assign cmd_ready_o = (state == ST_IDLE) && bus_free; // [RQ5]
    assign wr_ready_o  = (state == ST_FETCH);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= ST_IDLE;
            phase      <= PH_ADDR_W;
            cmd        <= '0;
            shreg      <= 8'h00;
            bit_cnt    <= 4'h0;
            quarter    <= 2'h0;
            last_byte  <= 1'h0;
            scl_o      <= 1'h1;
            sda_o      <= 1'h1;
            rd_valid_o <= 1'h0;
            rd_data_o  <= 8'h00;
            done_o     <= 1'h0;
            nack_o     <= 1'h0;
        end else begin
            rd_valid_o <= 1'h0;
            done_o     <= 1'h0;
            case (state)
                ST_IDLE: begin
                    scl_o   <= 1'h1;
                    sda_o   <= 1'h1;
                    quarter <= 2'h0;
                    if (cmd_valid_i && bus_free) begin // [RQ5]
                        cmd    <= cmd_i;
                        nack_o <= 1'h0;
                        phase  <= PH_ADDR_W;
                        shreg  <= {cmd_i.target, sensor_i2c_pkg::DIR_WRITE}; // [RQ2] [RQ6]
                        state  <= ST_START;
                    end
                end
                ST_START, ST_RESTART: if (tick) begin
                    // Restart raises SDA with SCL low, then SCL, then drops SDA
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: sda_o <= 1'h1;
                        2'h1: scl_o <= 1'h1;
                        2'h2: sda_o <= 1'h0;
                        default: begin
                            scl_o   <= 1'h0;
                            bit_cnt <= 4'h0;
                            state   <= ST_BYTE;
                        end
                    endcase
                end
                ST_BYTE: if (tick) begin
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: sda_o <= (phase == PH_DATA_R) ? 1'h1 : shreg[7]; // [RQ17]
                        2'h1: scl_o <= 1'h1;
                        2'h2: if (scl_s) shreg <= {shreg[6:0], sda_s}; // Stretched SCL holds the bit
                              else quarter <= 2'h2;
                        default: begin
                            scl_o   <= 1'h0;
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == sensor_i2c_pkg::BITS_PER_BYTE - 4'h1) state <= ST_ACK; // [RQ17]
                        end
                    endcase
                end
                ST_ACK: if (tick) begin
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: begin
                            if (phase == PH_DATA_R) begin
                                sda_o      <= last_byte; // [RQ13] [RQ14] [RQ15]
                                rd_valid_o <= 1'h1;
                                rd_data_o  <= shreg;
                            end else begin
                                sda_o <= 1'h1;
                            end
                        end
                        2'h1: scl_o <= 1'h1;
                        2'h2: if (!scl_s) quarter <= 2'h2;
                              else if (phase != PH_DATA_R && sda_s) nack_o <= 1'h1;
                        default: begin
                            scl_o   <= 1'h0;
                            bit_cnt <= 4'h0;
                            if (nack_o) begin
                                state <= ST_STOP;
                            end else begin
                                case (phase)
                                    PH_ADDR_W: begin
                                        phase <= PH_POINTER;
                                        shreg <= cmd.pointer; // [RQ6]
                                        state <= ST_BYTE;
                                    end
                                    PH_POINTER: begin
                                        if (is_read(cmd.op)) begin
                                            phase <= PH_ADDR_R;
                                            shreg <= {cmd.target, sensor_i2c_pkg::DIR_READ}; // [RQ2] [RQ9]
                                            state <= ST_RESTART; // [RQ11]
                                        end else begin
                                            phase <= PH_DATA_W;
                                            state <= ST_FETCH;
                                        end
                                    end
                                    PH_DATA_W: state <= last_byte ? ST_STOP : ST_FETCH; // [RQ3] [RQ7]
                                    PH_ADDR_R: begin
                                        phase     <= PH_DATA_R; // [RQ10]
                                        last_byte <= (cmd.op == sensor_i2c_pkg::OP_RANDOM_READ) || rd_last_i; // [RQ4]
                                        state     <= ST_BYTE;
                                    end
                                    default: begin
                                        // Host sets rd_last_i before this byte's acknowledge ends, ahead of the next byte; wrap is its concern
                                        last_byte <= rd_last_i; // [RQ16]
                                        state     <= last_byte ? ST_STOP : ST_BYTE; // [RQ15]
                                    end
                                endcase
                            end
                        end
                    endcase
                end
                ST_FETCH: if (wr_valid_i) begin
                    shreg     <= wr_data_i;
                    last_byte <= wr_last_i || (cmd.op == sensor_i2c_pkg::OP_BYTE_WRITE); // [RQ3]
                    quarter   <= 2'h0;
                    state     <= ST_BYTE;
                end
                ST_STOP: if (tick) begin
                    quarter <= quarter + 2'h1;
                    case (quarter)
                        2'h0: sda_o <= 1'h0;
                        2'h1: scl_o <= 1'h1;
                        2'h2: sda_o <= 1'h1; // [RQ13]
                        default: state <= ST_DONE;
                    endcase
                end
                ST_DONE: begin
                    done_o <= 1'h1;
                    state  <= ST_WAIT;
                end
                ST_WAIT: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Open drain: drive only a low level
    assign scl_oe_o = !scl_o;
    assign sda_oe_o = !sda_o;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_start_bus_free: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ5]
        $rose(state == ST_START) |-> $past(bus_free))
        else $error("START issued while bus not free");
    // Unstretched SCL high phase is two quarters, 100 core cycles; a stretching target would trip it
    a_tick_rate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ1]
        $rose(scl_o) && (state == ST_BYTE || state == ST_ACK) |-> ##99 scl_o ##1 !scl_o)
        else $error("SCL high time wrong");
    a_addr_write_byte: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ2]
        $rose(state == ST_START) |-> shreg[0] == sensor_i2c_pkg::DIR_WRITE)
        else $error("Write address byte has read direction");
    a_restart_read_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ11]
        $rose(state == ST_RESTART) |-> shreg[0] == sensor_i2c_pkg::DIR_READ && $past(phase) == PH_POINTER)
        else $error("Repeated START without read address");
    a_last_read_nack: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ13]
        rd_valid_o && last_byte |-> sda_o)
        else $error("Last read byte was acknowledged");
    a_seq_read_ack: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ14]
        rd_valid_o && !last_byte |-> !sda_o)
        else $error("Non-final read byte not acknowledged");
    a_nack_then_stop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ15]
        state == ST_ACK && phase == PH_DATA_R && last_byte && quarter == 2'h3 && tick && !nack_o
        |=> state == ST_STOP)
        else $error("No STOP after final read byte");
    a_pointer_follows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ6]
        $rose(phase == PH_POINTER) |-> shreg == cmd.pointer)
        else $error("Pointer byte does not follow address");
    a_byte_write_once: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ3]
        state == ST_FETCH && wr_valid_i && cmd.op == sensor_i2c_pkg::OP_BYTE_WRITE |=> last_byte)
        else $error("Single byte write not marked last");
endmodule : local_sensor_i2c_master

// ===== bench/sensor_target_model.sv
// Behavioural I2C target with an auto-incrementing pointer and a 256-byte store
`timescale 1ns/1ns
module sensor_target_model #(
    parameter logic [6:0] ADDR = 7'h29
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_oe_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] mem [256];
    logic [7:0] ptr = 8'h00, sh = 8'h00, tx = 8'h00;
    logic       act = 0, first = 0, ptr_ph = 0, rd = 0, go = 0;
    int         bitn = 0, wcnt = 0, acks = 0, nacks = 0, stops = 0;

    initial begin
        sda_oe_o = 0;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    // ----------------------------------------
    // Framing
    // ----------------------------------------
    // Start and repeated start both restart the byte framing
    always @(negedge sda_i) if (scl_i) begin
        act = 1; first = 1; rd = 0; go = 0; bitn = -1; sda_oe_o = 0;
    end
    always @(posedge sda_i) if (scl_i) begin
        act = 0; stops++;
    end
    always @(posedge scl_i) if (act) begin
        if (bitn < 8) sh = {sh[6:0], sda_i};
        else if (rd && !sda_oe_o) begin
            go = !sda_i;
            if (sda_i) nacks++; else acks++;
        end
    end
    // Drive changes well after SCL falls so that SDA never moves near the high phase
    always @(negedge scl_i) if (act) begin
        #300;
        if (bitn < 7) begin
            bitn++;
            sda_oe_o = rd && !tx[7 - bitn];
        end else if (bitn == 7) begin
            bitn = 8;
            if (first) begin
                first = 0; rd = sh[0]; ptr_ph = !sh[0]; go = sh[0];
                act = (sh[7:1] == ADDR);
                sda_oe_o = act;
            end else if (rd) begin
                sda_oe_o = 0;
                ptr++;
            end else if (ptr_ph) begin
                ptr = sh; ptr_ph = 0; sda_oe_o = 1;
            end else begin
                mem[ptr] = sh; ptr++; wcnt++; sda_oe_o = 1;
            end
        end else begin
            bitn = 0;
            tx = mem[ptr];
            sda_oe_o = rd && go && !tx[7];
        end
    end
endmodule : sensor_target_model

// ===== bench/tb.sv
// Self-checking bench for the local sensor I2C master
`timescale 1ns/1ns
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [6:0] TGT = 7'h29;
    typedef struct {
        sensor_i2c_pkg::op_t op;
        logic [6:0]          tgt;
        logic [7:0]          ptr;
        int                  n;
        logic [7:0]          d0;
        logic                nack;
    } row_t;
    logic                 core_clk_i = 0, rst_n_i = 0, cmd_valid_i = 0, wr_valid_i = 0, wr_last_i = 0, rd_last_i = 0;
    sensor_i2c_pkg::cmd_t cmd_i = '0;
    logic [7:0]           wr_data_i = 8'h00, rd_data_o;
    logic                 cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, t_oe;
    int                   miscompares = 0, checked = 0, cyc = 0;
    time                  last_rise = 0, per = 0, snap = 0;
    // Pull-ups: a released line reads high
    wire scl = !scl_oe_o;
    wire sda = !(sda_oe_o || t_oe);
    // Page write and sequential read both run over the pointer wrap
    row_t rows [5] = '{
        '{sensor_i2c_pkg::OP_BYTE_WRITE,  TGT,   8'h10, 1, 8'ha5, 1'b0},
        '{sensor_i2c_pkg::OP_PAGE_WRITE,  TGT,   8'hfe, 3, 8'h31, 1'b0},
        '{sensor_i2c_pkg::OP_RANDOM_READ, TGT,   8'h10, 1, 8'ha5, 1'b0},
        '{sensor_i2c_pkg::OP_SEQ_READ,    TGT,   8'hfe, 3, 8'h31, 1'b0},
        '{sensor_i2c_pkg::OP_BYTE_WRITE,  7'h33, 8'h20, 1, 8'h00, 1'b1}
    };

    always #25 core_clk_i = !core_clk_i;
    always @(posedge scl) begin
        per = $time - last_rise;
        last_rise = $time;
    end
    always @(negedge core_clk_i) if (rd_valid_o === 1'b1) snap = per;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            give_verdict();
        end
    end

    local_sensor_i2c_master dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .cmd_ready_o(cmd_ready_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_last_i(wr_last_i),
        .wr_ready_o(wr_ready_o), .rd_last_i(rd_last_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .done_o(done_o), .nack_o(nack_o), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
    );
    sensor_target_model #(.ADDR(TGT)) sensor (.scl_i(scl), .sda_i(sda), .sda_oe_o(t_oe));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp8

    task automatic cmp_int(input string name, input int exp, input int got);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : cmp_int

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // Holds the command up until taken, then feeds write bytes and collects read bytes
    task automatic run(input row_t r);
        int         w0, a0, n0, s0, k;
        logic [7:0] got [$];
        logic       wr;
        logic       rdy;
        w0 = sensor.wcnt; a0 = sensor.acks; n0 = sensor.nacks; s0 = sensor.stops; k = 0;
        wr = r.op inside {sensor_i2c_pkg::OP_BYTE_WRITE, sensor_i2c_pkg::OP_PAGE_WRITE};
        @(negedge core_clk_i);
        cmd_i = '{op: r.op, target: r.tgt, pointer: r.ptr};
        cmd_valid_i = 1;
        rd_last_i = r.op == sensor_i2c_pkg::OP_SEQ_READ && r.n == 1;
        // Ready is settled at the falling edge; the rising edge after it takes the command
        while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        cmd_valid_i = 0;
        cmp8("cmd_ready_busy", 8'h00, {7'h00, cmd_ready_o});
        rdy = 1'b0;
        forever begin
            @(negedge core_clk_i);
            if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
            // A byte offered while ready stood has been taken at the rising edge just passed
            if (wr_valid_i && rdy) k++;
            if (done_o === 1'b1) break;
            rdy = (wr_ready_o === 1'b1);
            wr_valid_i = wr && k < r.n;
            wr_data_i = r.d0 + 8'(k);
            wr_last_i = k == r.n - 1;
            rd_last_i = r.op == sensor_i2c_pkg::OP_SEQ_READ && got.size() >= r.n - 1;
        end
        wr_valid_i = 0;
        cmp8("nack_o", {7'h00, r.nack}, {7'h00, nack_o});
        cmp_int("stops", 1, sensor.stops - s0);
        if (wr) begin
            cmp_int("bytes_stored", r.nack ? 0 : r.n, sensor.wcnt - w0);
            for (int i = 0; i < r.n && !r.nack; i++) cmp8("stored", r.d0 + 8'(i), sensor.mem[r.ptr + 8'(i)]);
        end else begin
            cmp_int("read_count", r.n, got.size());
            cmp_int("master_acks", r.n - 1, sensor.acks - a0);
            cmp_int("master_nacks", 1, sensor.nacks - n0);
            for (int i = 0; i < got.size(); i++) cmp8("read_data", r.d0 + 8'(i), got[i]);
        end
    endtask : run

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge core_clk_i);
        cmp8("oe_in_reset", 8'h00, {6'h00, scl_oe_o, sda_oe_o});
        repeat (9) @(negedge core_clk_i);
        rst_n_i = 1;
        repeat (150) @(negedge core_clk_i);
        cmp8("cmd_ready_early", 8'h00, {7'h00, cmd_ready_o});
        foreach (rows[i]) run(rows[i]);
        // Reset after a command is taken but before its START: lines released, then a clean transfer
        @(negedge core_clk_i);
        cmd_i = '{op: sensor_i2c_pkg::OP_PAGE_WRITE, target: TGT, pointer: 8'h40};
        cmd_valid_i = 1;
        while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        cmd_valid_i = 0;
        repeat (100) @(negedge core_clk_i);
        rst_n_i = 0;
        @(negedge core_clk_i);
        cmp8("oe_mid_reset", 8'h00, {5'h00, done_o, scl_oe_o, sda_oe_o});
        rst_n_i = 1;
        repeat (2) @(negedge core_clk_i);
        cmp8("ready_after_reset", 8'h00, {7'h00, cmd_ready_o});
        run(rows[0]);
        cmp_int("scl_period_ns", 10000, int'(snap));
        give_verdict();
    end
endmodule : tb
